// ==== src/lpm_pkg.sv ====
package lpm_pkg;

  // ---------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_DEEP_SLEEP,
    ST_HIBERNATE,
    ST_STOP
  } power_state_t;

  // ---------------------------------------------------------------
  // Reset cause encoding
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CAUSE_POWER_CYCLE,
    CAUSE_HIBERNATE_WAKE,
    CAUSE_WAKE_PIN,
    CAUSE_COUNTER_RESET
  } reset_cause_t;

  localparam logic [1:0] RESET_CAUSE_RST = 2'h0;

  // ---------------------------------------------------------------
  // Wake sources
  // ---------------------------------------------------------------
  typedef struct packed {
    logic i2c_match;
    logic counter_irq;
    logic gpio_irq;
    logic ct_comp_irq;
    logic lp_comp_irq;
  } wake_src_t;

  localparam int WAKE_SRC_W = 5;
  localparam logic [4:0] WAKE_SRC_RST = 5'h00;

  // ---------------------------------------------------------------
  // Software requests
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sleep_req;
    logic deep_sleep_entry_request;
    logic hibernate_entry_request;
    logic stop_entry_request;
    logic io_freeze_request;
    logic io_unfreeze_request;
  } sw_req_t;

  // ---------------------------------------------------------------
  // Clock and domain enables
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cpu_run;
    logic hf_clk_en;
    logic hf_periph_en;
    logic lf_clk_en;
    logic serial_comm_block_en;
    logic ct_block_en;
    logic lp_comp_en;
    logic sram_retain;
    logic digital_retain;
  } domain_en_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int HOLDOFF_CYCLES  = 16;
  localparam int CNT_W           = 16;
  localparam int NUM_COUNTERS    = 2;

endpackage : lpm_pkg

// ==== src/sleep_wake_counter.sv ====
`timescale 1ns/1ns
module sleep_wake_counter
  import lpm_pkg::*;
#(
  parameter int N = NUM_COUNTERS,
  parameter int W = CNT_W
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           lf_run,
  input  wire logic [N-1:0]   cnt_en,
  input  wire logic [N*W-1:0] cnt_limit,
  input  wire logic [N-1:0]   irq_en,
  input  wire logic [N-1:0]   rst_en,
  output logic                irq_evt,
  output logic                rst_evt
);

  logic [N*W-1:0] cnt_q;
  logic [N-1:0]   hit;

  // ---------------------------------------------------------------
  // Independent counters on the low-speed oscillator.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (lf_run) begin
      for (int i = 0; i < N; i++) begin
        if (!cnt_en[i] || hit[i]) begin
          cnt_q[i*W +: W] <= '0;
        end else begin
          cnt_q[i*W +: W] <= cnt_q[i*W +: W] + W'(1);
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      hit[i] = lf_run && cnt_en[i] &&
               (cnt_q[i*W +: W] == cnt_limit[i*W +: W]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_evt <= 1'b0;
      rst_evt <= 1'b0;
    end else begin
      irq_evt <= |(hit & irq_en);
      rst_evt <= |(hit & rst_en);
    end
  end

endmodule : sleep_wake_counter

// ==== src/low_power_mode_controller.sv ====
`timescale 1ns/1ns
// What this block does
// - Deep sleep switches off high-frequency clocks and their peripherals.
// - Low-speed oscillator runs in deep sleep and clocks wake counters.
// - Serial block watches I2C in deep sleep; address match wakes.
// - Deep sleep exits on I2C, counter, GPIO, CT or LP comparator.
// - Each counter may raise an interrupt, a reset, or both.
// - Early deep sleep request enters sleep, then deep sleep after hold-off.
// - Enabled wake interrupt returns to active without reset.
// - Hibernate stops clocks, keeps SRAM and digital block state.
// - Pin or LP comparator wakes hibernate by reset keeping retained state.
// - Reset cause distinguishes hibernate wake from other resets.
// - Interrupt state of the hibernate wake source survives the reset.
// - Software may freeze pins before hibernate; unfreeze needed after.
// - Stop disables all and loses state; frozen pins hold.
// - Of the wake sources only the wake pin leaves stop; its edge is selectable.
// - Stop entry freezes all pins by itself.
// - Stop exits on wake pin, reset pin low, or power cycle, by reset.
// - After stop exit, cause says wake pin or power cycle.
// - After wake pin reset, pins stay frozen until explicit unfreeze.
// - Power cycle or reset pin low ends any mode, drops retained state.
// - Reset pin clears frozen pins; wake cause is lost.
// - Sleep halts the processor; any interrupt wakes it.
// - Frozen pins stay locked until unfrozen in active mode or cleared by reset pin low or power cycle.
module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int HOLDOFF = HOLDOFF_CYCLES,
  parameter int NCNT    = NUM_COUNTERS,
  parameter int CW      = CNT_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              power_good,
  input  wire logic              external_reset_pin_n,
  input  wire logic              dedicated_wake_pin,
  input  wire logic              wake_edge_select,
  input  wire logic              system_ready,
  input  wire lpm_pkg::sw_req_t  sw_req,
  input  wire logic              any_irq,
  input  wire lpm_pkg::wake_src_t wake_src,
  input  wire lpm_pkg::wake_src_t wake_irq_en,
  input  wire logic [NCNT-1:0]   cnt_en,
  input  wire logic [NCNT*CW-1:0] cnt_limit,
  input  wire logic [NCNT-1:0]   cnt_irq_en,
  input  wire logic [NCNT-1:0]   cnt_rst_en,
  output lpm_pkg::power_state_t  power_state,
  output lpm_pkg::domain_en_t    domain_en,
  output logic                   io_frozen,
  output logic                   device_reset,
  output logic                   retained_valid,
  output lpm_pkg::reset_cause_t  reset_cause_query,
  output lpm_pkg::wake_src_t     wake_latch,
  output logic                   wake_irq
);

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic       wpin_prev_q;
  logic       external_reset_pin_n_s;
  logic       pgood_s;
  logic       wpin_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {power_good, external_reset_pin_n, dedicated_wake_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign pgood_s  = pin_s2_q[2];
  assign external_reset_pin_n_s = pin_s2_q[1];
  assign wpin_s   = pin_s2_q[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wpin_prev_q <= 1'b0;
    end else begin
      wpin_prev_q <= wpin_s;
    end
  end

  // ---------------------------------------------------------------
  // Hard reset and wake pin edge.
  // ---------------------------------------------------------------
  logic hard_rst;
  logic wpin_edge;
  logic armed_q;

  // The synchronisers come out of reset low, so the hard reset is
  // held off until both pins have been sampled high once.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (pgood_s && external_reset_pin_n_s) begin
      armed_q <= 1'b1;
    end
  end

  assign hard_rst  = armed_q && (!pgood_s || !external_reset_pin_n_s);
  assign wpin_edge = wake_edge_select ? (wpin_s && !wpin_prev_q)
                                      : (!wpin_s && wpin_prev_q);

  // ---------------------------------------------------------------
  // Wake counters.
  // ---------------------------------------------------------------
  logic       lf_run;
  logic       cnt_irq;
  logic       cnt_rst;
  power_state_t state_q;

  assign lf_run = (state_q != ST_HIBERNATE) && (state_q != ST_STOP);

  sleep_wake_counter #(
    .N (NCNT),
    .W (CW)
  ) u_counter (
    .clk       (clk),
    .rst_n     (rst_n),
    .lf_run    (lf_run),
    .cnt_en    (cnt_en),
    .cnt_limit (cnt_limit),
    .irq_en    (cnt_irq_en),
    .rst_en    (cnt_rst_en),
    .irq_evt   (cnt_irq),
    .rst_evt   (cnt_rst)
  );

  // ---------------------------------------------------------------
  // Wake decode.
  // ---------------------------------------------------------------
  wake_src_t live_src;
  wake_src_t ds_wake;
  wake_src_t hib_wake;

  always_comb begin
    live_src             = wake_src;
    live_src.counter_irq = wake_src.counter_irq | cnt_irq;
    ds_wake              = live_src & wake_irq_en;
    hib_wake             = WAKE_SRC_RST;
    hib_wake.gpio_irq    = live_src.gpio_irq & wake_irq_en.gpio_irq;
    hib_wake.lp_comp_irq = live_src.lp_comp_irq & wake_irq_en.lp_comp_irq;
  end

  // ---------------------------------------------------------------
  // Power state machine.
  // ---------------------------------------------------------------
  logic [CW-1:0] hold_q;
  logic          ds_pending_q;
  logic          soft_rst;

  always_ff @(posedge clk) begin
    if (!rst_n || hard_rst) begin
      state_q <= ST_ACTIVE;
    end else begin
      unique case (state_q)
        ST_ACTIVE: begin
          if (sw_req.stop_entry_request) begin
            state_q <= ST_STOP;
          end else if (sw_req.hibernate_entry_request) begin
            state_q <= ST_HIBERNATE;
          end else if (sw_req.deep_sleep_entry_request) begin
            state_q <= system_ready ? ST_DEEP_SLEEP : ST_SLEEP;
          end else if (sw_req.sleep_req) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (any_irq || cnt_irq || cnt_rst) begin
            state_q <= ST_ACTIVE;
          end else if (ds_pending_q && hold_q == '0) begin
            state_q <= ST_DEEP_SLEEP;
          end
        end
        ST_DEEP_SLEEP: begin
          if ((|ds_wake) || cnt_rst) begin
            state_q <= ST_ACTIVE;
          end
        end
        ST_HIBERNATE: begin
          if (|hib_wake) begin
            state_q <= ST_ACTIVE;
          end
        end
        ST_STOP: begin
          if (wpin_edge) begin
            state_q <= ST_ACTIVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || hard_rst) begin
      ds_pending_q <= 1'b0;
      hold_q       <= '0;
    end else if (state_q == ST_ACTIVE && sw_req.deep_sleep_entry_request &&
                 !sw_req.stop_entry_request &&
                 !sw_req.hibernate_entry_request && !system_ready) begin
      ds_pending_q <= 1'b1;
      hold_q       <= CW'(HOLDOFF);
    end else if (state_q != ST_SLEEP) begin
      ds_pending_q <= 1'b0;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - CW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Device reset pulse and reset cause.
  // ---------------------------------------------------------------
  assign soft_rst = ((state_q == ST_HIBERNATE) && (|hib_wake)) ||
                    ((state_q == ST_STOP) && wpin_edge) ||
                    (((state_q == ST_DEEP_SLEEP) ||
                      (state_q == ST_SLEEP)) && cnt_rst);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= soft_rst || hard_rst;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || hard_rst) begin
      reset_cause_query <= reset_cause_t'(RESET_CAUSE_RST);
    end else if (state_q == ST_HIBERNATE && (|hib_wake)) begin
      reset_cause_query <= CAUSE_HIBERNATE_WAKE;
    end else if (state_q == ST_STOP && wpin_edge) begin
      reset_cause_query <= CAUSE_WAKE_PIN;
    end else if (soft_rst) begin
      reset_cause_query <= CAUSE_COUNTER_RESET;
    end
  end

  // ---------------------------------------------------------------
  // Retained wake source and retention.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || hard_rst) begin
      wake_latch <= WAKE_SRC_RST;
    end else if (state_q == ST_HIBERNATE && (|hib_wake)) begin
      wake_latch <= hib_wake;
    end else if (state_q == ST_DEEP_SLEEP && (|ds_wake)) begin
      wake_latch <= ds_wake;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || hard_rst) begin
      retained_valid <= 1'b0;
    end else if (state_q == ST_STOP) begin
      retained_valid <= 1'b0;
    end else if (state_q == ST_HIBERNATE) begin
      retained_valid <= 1'b1;
    end else if (state_q == ST_ACTIVE && sw_req.io_unfreeze_request) begin
      retained_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= (state_q == ST_DEEP_SLEEP) && (|ds_wake) && !cnt_rst;
    end
  end

  // ---------------------------------------------------------------
  // I/O freeze.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || hard_rst) begin
      io_frozen <= 1'b0;
    end else if (state_q == ST_ACTIVE && sw_req.stop_entry_request) begin
      io_frozen <= 1'b1;
    end else if (state_q == ST_ACTIVE && sw_req.io_freeze_request) begin
      io_frozen <= 1'b1;
    end else if (state_q == ST_ACTIVE && sw_req.io_unfreeze_request) begin
      io_frozen <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Domain enables.
  // ---------------------------------------------------------------
  always_comb begin
    domain_en = '0;
    unique case (state_q)
      ST_ACTIVE: begin
        domain_en = '1;
        domain_en.sram_retain    = 1'b0;
        domain_en.digital_retain = 1'b0;
      end
      ST_SLEEP: begin
        domain_en = '1;
        domain_en.cpu_run        = 1'b0;
        domain_en.sram_retain    = 1'b0;
        domain_en.digital_retain = 1'b0;
      end
      ST_DEEP_SLEEP: begin
        domain_en.lf_clk_en            = 1'b1;
        domain_en.serial_comm_block_en = 1'b1;
        domain_en.ct_block_en          = 1'b1;
        domain_en.lp_comp_en           = 1'b1;
        domain_en.sram_retain          = 1'b1;
        domain_en.digital_retain       = 1'b1;
      end
      ST_HIBERNATE: begin
        domain_en.lp_comp_en     = 1'b1;
        domain_en.sram_retain    = 1'b1;
        domain_en.digital_retain = 1'b1;
      end
      ST_STOP: begin
        domain_en = '0;
      end
    endcase
  end

  assign power_state = state_q;

endmodule : low_power_mode_controller

// ==== verif/lpm_monitor.sv ====
`timescale 1ns/1ns
module lpm_monitor
  import lpm_pkg::*;
#(
  parameter int HOLDOFF = HOLDOFF_CYCLES,
  parameter int NCNT    = NUM_COUNTERS,
  parameter int CW      = CNT_W
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  power_good,
  input wire logic                  external_reset_pin_n,
  input wire logic                  system_ready,
  input wire lpm_pkg::sw_req_t      sw_req,
  input wire lpm_pkg::wake_src_t    wake_src,
  input wire lpm_pkg::wake_src_t    wake_irq_en,
  input wire logic [NCNT-1:0]       cnt_rst_en,
  input wire lpm_pkg::power_state_t power_state,
  input wire lpm_pkg::domain_en_t   domain_en,
  input wire logic                  io_frozen,
  input wire logic                  device_reset,
  input wire logic                  retained_valid,
  input wire lpm_pkg::reset_cause_t reset_cause_query,
  input wire lpm_pkg::wake_src_t    wake_latch,
  input wire logic                  wake_irq
);
  // ------------------------------------------------------------
  // Calm is high once both supply pins have stayed high a while.
  // ------------------------------------------------------------
  logic [2:0] calm_q;
  logic       calm;
  always_ff @(posedge clk) begin
    if (!rst_n || !power_good || !external_reset_pin_n) calm_q <= 3'h0;
    else if (calm_q != 3'h7) calm_q <= calm_q + 3'h1;
  end
  assign calm = (calm_q == 3'h7);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_armed;
    calm && power_state == ST_ACTIVE;
  endsequence
  sequence s_external_reset_pin;
    calm ##1 !external_reset_pin_n [*5];
  endsequence

  property p_stop_entry;
    s_armed ##0 sw_req.stop_entry_request
      |=> power_state == ST_STOP && io_frozen;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop entry");
  property p_ds_entry;
    s_armed ##0 (sw_req.deep_sleep_entry_request && sw_req[3:2] == 2'h0)
      |=> power_state == ($past(system_ready) ? ST_DEEP_SLEEP : ST_SLEEP);
  endproperty
  a_ds_entry: assert property (p_ds_entry) else $error("deep entry");
  property p_ds_dom;
    power_state == ST_DEEP_SLEEP |-> !domain_en.hf_clk_en &&
      !domain_en.hf_periph_en && domain_en.lf_clk_en &&
      domain_en.serial_comm_block_en;
  endproperty
  a_ds_dom: assert property (p_ds_dom) else $error("deep domains");
  property p_hib_dom;
    power_state == ST_HIBERNATE |-> !domain_en.hf_clk_en &&
      !domain_en.lf_clk_en && domain_en.sram_retain && domain_en.digital_retain;
  endproperty
  a_hib_dom: assert property (p_hib_dom) else $error("hib domains");
  property p_stop_dom;
    power_state == ST_STOP |-> domain_en == '0 && io_frozen;
  endproperty
  a_stop_dom: assert property (p_stop_dom) else $error("stop domains");
  property p_ds_wake;
    power_state == ST_DEEP_SLEEP && calm && cnt_rst_en == '0 &&
      (|(wake_src & wake_irq_en))
      |=> power_state == ST_ACTIVE && wake_irq && !device_reset;
  endproperty
  a_ds_wake: assert property (p_ds_wake) else $error("deep wake");
  property p_hib_wake;
    $past(power_state) == ST_HIBERNATE && power_state == ST_ACTIVE && calm
      |-> device_reset && retained_valid && wake_latch != '0 &&
      reset_cause_query == CAUSE_HIBERNATE_WAKE;
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hib wake");
  property p_stop_wake;
    $past(power_state) == ST_STOP && power_state == ST_ACTIVE && calm
      |-> device_reset && io_frozen && reset_cause_query == CAUSE_WAKE_PIN;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake");
  property p_hold;
    io_frozen && calm &&
      !(power_state == ST_ACTIVE && sw_req.io_unfreeze_request) |=> io_frozen;
  endproperty
  a_hold: assert property (p_hold) else $error("pins unlocked");
  property p_external_reset_pin;
    s_external_reset_pin |-> power_state == ST_ACTIVE && !io_frozen && device_reset &&
      !retained_valid && reset_cause_query == CAUSE_POWER_CYCLE &&
      wake_latch == WAKE_SRC_RST;
  endproperty
  a_external_reset_pin: assert property (p_external_reset_pin) else $error("reset pin");
  property p_only_active;
    $changed(power_state) && !(power_state inside {ST_ACTIVE, ST_DEEP_SLEEP})
      |-> $past(power_state) == ST_ACTIVE;
  endproperty
  a_only_active: assert property (p_only_active) else $error("entry");
endmodule : lpm_monitor

bind low_power_mode_controller lpm_monitor #(
  .HOLDOFF(HOLDOFF),
  .NCNT   (NCNT),
  .CW     (CW)
) u_mon (
  .clk                  (clk),
  .rst_n                (rst_n),
  .power_good           (power_good),
  .external_reset_pin_n (external_reset_pin_n),
  .system_ready         (system_ready),
  .sw_req               (sw_req),
  .wake_src             (wake_src),
  .wake_irq_en          (wake_irq_en),
  .cnt_rst_en           (cnt_rst_en),
  .power_state          (power_state),
  .domain_en            (domain_en),
  .io_frozen            (io_frozen),
  .device_reset         (device_reset),
  .retained_valid       (retained_valid),
  .reset_cause_query    (reset_cause_query),
  .wake_latch           (wake_latch),
  .wake_irq             (wake_irq)
);

// ==== verif/lpm_host_model.sv ====
`timescale 1ns/1ns
module lpm_host_model (
  input  wire logic clk,
  input  wire logic edge_sel,
  input  wire logic wake_go,
  input  wire logic external_reset_pin_go,
  input  wire logic drop_go,
  output logic      power_good,
  output logic      external_reset_pin_n,
  output logic      dedicated_wake_pin
);
  logic [3:0] wake_q = 4'h0;
  logic [3:0] external_reset_pin_q = 4'h0;
  logic [3:0] drop_q = 4'h0;
  always_ff @(posedge clk) begin
    wake_q <= wake_go ? 4'h8 : wake_q - {3'h0, wake_q != 4'h0};
    external_reset_pin_q <= external_reset_pin_go ? 4'h8 : external_reset_pin_q - {3'h0, external_reset_pin_q != 4'h0};
    drop_q <= drop_go ? 4'h8 : drop_q - {3'h0, drop_q != 4'h0};
  end
  // The pin idles at the level set by the chosen edge, so a press first
  // makes the ignored edge and ends with the waking one.
  assign dedicated_wake_pin   = (wake_q != 4'h0) ? ~edge_sel : edge_sel;
  assign external_reset_pin_n = (external_reset_pin_q == 4'h0);
  assign power_good           = (drop_q == 4'h0);
endmodule : lpm_host_model

// ==== verif/test_low_power_mode_controller.sv ====
`timescale 1ns/1ns
module test_low_power_mode_controller;
  import lpm_pkg::*;
  localparam int HO = 4;
  logic         clk, rst_n, power_good, external_reset_pin_n;
  logic         dedicated_wake_pin, wake_edge_select, system_ready;
  logic         any_irq, io_frozen, device_reset, retained_valid, wake_irq;
  logic         wake_go, external_reset_pin_go, drop_go;
  logic [1:0]   cnt_en, cnt_irq_en, cnt_rst_en;
  logic [31:0]  cnt_limit;
  sw_req_t      sw_req;
  wake_src_t    wake_src, wake_irq_en, wake_latch;
  power_state_t power_state;
  domain_en_t   domain_en;
  reset_cause_t reset_cause_query;
  int           failures, samples_checked, n;

  low_power_mode_controller #(.HOLDOFF(HO)) uut (
    .clk                  (clk),
    .rst_n                (rst_n),
    .power_good           (power_good),
    .external_reset_pin_n (external_reset_pin_n),
    .dedicated_wake_pin   (dedicated_wake_pin),
    .wake_edge_select     (wake_edge_select),
    .system_ready         (system_ready),
    .sw_req               (sw_req),
    .any_irq              (any_irq),
    .wake_src             (wake_src),
    .wake_irq_en          (wake_irq_en),
    .cnt_en               (cnt_en),
    .cnt_limit            (cnt_limit),
    .cnt_irq_en           (cnt_irq_en),
    .cnt_rst_en           (cnt_rst_en),
    .power_state          (power_state),
    .domain_en            (domain_en),
    .io_frozen            (io_frozen),
    .device_reset         (device_reset),
    .retained_valid       (retained_valid),
    .reset_cause_query    (reset_cause_query),
    .wake_latch           (wake_latch),
    .wake_irq             (wake_irq)
  );
  lpm_host_model host (.clk(clk), .edge_sel(wake_edge_select),
    .wake_go(wake_go), .external_reset_pin_go(external_reset_pin_go), .drop_go(drop_go),
    .power_good(power_good), .external_reset_pin_n(external_reset_pin_n),
    .dedicated_wake_pin(dedicated_wake_pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task results;
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task step;
    @(posedge clk);
    #1;
  endtask : step

  task req(input logic [5:0] r);
    @(posedge clk);
    sw_req <= r;
    @(posedge clk);
    sw_req <= '0;
    #1;
  endtask : req

  task wait_for(input power_state_t s, input int lim);
    n = 0;
    while (power_state !== s && n < lim) begin
      step();
      n++;
    end
    if (power_state !== s) begin
      failures++;
      results();
    end
  endtask : wait_for

  task t_deep;
    logic [4:0] b;
    for (int i = 0; i < 5; i++) begin
      b = 5'h10 >> i;
      req(6'h10);
      check(power_state, ST_DEEP_SLEEP);
      check({domain_en.hf_clk_en, domain_en.lf_clk_en}, 2'h1);
      check(domain_en.serial_comm_block_en, 1'b1);
      @(posedge clk);
      wake_irq_en <= ~b;
      wake_src <= b;
      repeat (3) step();
      check(power_state, ST_DEEP_SLEEP);
      @(posedge clk);
      wake_irq_en <= '1;
      step();
      check({wake_irq, device_reset, power_state}, {2'h2, ST_ACTIVE});
      check(wake_latch, b);
      wake_src <= '0;
    end
  endtask : t_deep

  task t_sleep;
    req(6'h20);
    check(power_state, ST_SLEEP);
    check(domain_en.cpu_run, 1'b0);
    @(posedge clk);
    any_irq <= 1'b1;
    step();
    check(power_state, ST_ACTIVE);
    any_irq <= 1'b0;
    system_ready <= 1'b0;
    req(6'h10);
    check(power_state, ST_SLEEP);
    wait_for(ST_DEEP_SLEEP, 4 * HO);
    check(n >= HO - 1 && n <= HO + 2, 1'b1);
    system_ready <= 1'b1;
    wake_src <= 5'h04;
    step();
    check(power_state, ST_ACTIVE);
    wake_src <= '0;
  endtask : t_sleep

  task t_counter;
    req(6'h10);
    cnt_limit <= 32'h0010_0008;
    cnt_irq_en <= 2'h1;
    cnt_en <= 2'h1;
    wait_for(ST_ACTIVE, 2000);
    check({wake_irq, device_reset}, 2'h2);
    cnt_en <= 2'h0;
    req(6'h10);
    cnt_rst_en <= 2'h2;
    cnt_en <= 2'h2;
    wait_for(ST_ACTIVE, 2000);
    check({device_reset, reset_cause_query}, {1'b1, CAUSE_COUNTER_RESET});
    cnt_en <= 2'h0;
    cnt_rst_en <= 2'h0;
  endtask : t_counter

  task t_hib(input logic [4:0] b);
    req(6'h02);
    check(io_frozen, 1'b1);
    req(6'h08);
    check({domain_en.sram_retain, domain_en.lf_clk_en}, 2'h2);
    req(6'h20);
    req(6'h01);
    check({power_state, io_frozen}, {ST_HIBERNATE, 1'b1});
    wake_src <= b;
    wait_for(ST_ACTIVE, 8);
    check({device_reset, retained_valid, reset_cause_query}, 4'hD);
    check({wake_latch, io_frozen}, {b, 1'b1});
    wake_src <= '0;
    req(6'h01);
    check(io_frozen, 1'b0);
  endtask : t_hib

  task t_stop(input logic p);
    wake_edge_select <= p;
    repeat (6) step();
    req(6'h04);
    check({power_state, io_frozen, domain_en}, {ST_STOP, 10'h200});
    wake_src <= '1;
    any_irq <= 1'b1;
    @(posedge clk);
    wake_go <= 1'b1;
    @(posedge clk);
    wake_go <= 1'b0;
    wake_src <= '0;
    any_irq <= 1'b0;
    repeat (6) step();
    check(power_state, ST_STOP);
    wait_for(ST_ACTIVE, 20);
    check({device_reset, io_frozen, reset_cause_query}, 4'hE);
    req(6'h01);
    check(io_frozen, 1'b0);
  endtask : t_stop

  task t_hard;
    req(6'h02);
    req(6'h08);
    external_reset_pin_go <= 1'b1;
    step();
    external_reset_pin_go <= 1'b0;
    repeat (16) step();
    check({power_state, io_frozen, retained_valid}, 5'h00);
    check({reset_cause_query, wake_latch}, 7'h00);
    req(6'h04);
    drop_go <= 1'b1;
    step();
    drop_go <= 1'b0;
    repeat (16) step();
    check({power_state, io_frozen, device_reset}, 5'h00);
  endtask : t_hard

  initial begin
    {rst_n, any_irq, wake_go, external_reset_pin_go, drop_go} = 5'h00;
    {wake_edge_select, system_ready} = 2'h3;
    sw_req = '0;
    wake_src = '0;
    wake_irq_en = '1;
    {cnt_en, cnt_irq_en, cnt_rst_en} = 6'h00;
    cnt_limit = 32'h0000_0000;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) step();
    check({power_state, io_frozen, device_reset, wake_latch}, 10'h000);
    t_deep();
    t_sleep();
    t_counter();
    t_hib(5'h04);
    t_hib(5'h01);
    t_stop(1'b1);
    t_stop(1'b0);
    t_hard();
    results();
  end
endmodule : test_low_power_mode_controller
